// >>> dv/tb_top.sv
// Self-checking testbench for the reloadable countdown timers.
`timescale 1ns/1ps
module tb_top;
	import rct_pkg::*;

	logic         pclk;
	logic         presetn;
	logic [11:0]  paddr;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	rct_rf_type   rf;
	rct_tick_type tick;
	logic         timer_b_underflow;
	logic         timer_c_underflow;
	logic         timer_c_underflow_flag;
	int           err_count;
	int           checks;
	int           uf_c;
	int           uf_b;
	logic [31:0]  d;
	logic         e;

	rct_timers uut
	(
		.pclk                   (pclk),
		.presetn                (presetn),
		.paddr                  (paddr),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.pwdata                 (pwdata),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.rf                     (rf),
		.tick                   (tick),
		.timer_b_underflow      (timer_b_underflow),
		.timer_c_underflow      (timer_c_underflow),
		.timer_c_underflow_flag (timer_c_underflow_flag)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Underflow pulses are counted here, so a pulse of the wrong length shows as a count error.
	always @(posedge pclk)
	begin
		if (timer_c_underflow === 1'b1) uf_c <= uf_c + 1;
		if (timer_b_underflow === 1'b1) uf_b <= uf_b + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 32'h1, 32'h0);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b1, idx, v, d, e);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, d, e);
		chk($sformatf("reg %h", idx), {24'h000000, exp}, d);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask : rd

	task automatic set_c(input logic [7:0] ctl, input logic [15:0] rl);
		wr(IDX_COMMAND, 8'h38);
		wr(IDX_C_CONTROL, ctl);
		wr(IDX_C_RELOAD_HIGH, rl[15:8]);
		wr(IDX_C_RELOAD_LOW, rl[7:0]);
	endtask : set_c

	task automatic tk(input logic [2:0] v, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			tick <= v;
			@(posedge pclk);
			tick <= 3'b000;
		end
	endtask : tk

	// The oscillator level is kept after the pulse; the other two lines are one-cycle pulses.
	task automatic rfp(input logic [2:0] v);
		@(posedge pclk);
		rf <= v;
		@(posedge pclk);
		rf <= {2'b00, v[0]};
	endtask : rfp

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_count++;
		summarize();
	end

	initial
	begin
		err_count = 0;
		checks = 0;
		uf_c = 0;
		uf_b = 0;
		presetn = 1'b0;
		paddr = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = '0;
		rf = 3'b000;
		tick = 3'b000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_C_CONTROL, 8'h00);
		rd(IDX_C_RELOAD_HIGH, 8'h00);
		rd(IDX_B_RELOAD_LOW, 8'h00);
		rd(IDX_B_COUNT_HIGH, 8'h00);
		wr(IDX_C_CONTROL, 8'hff);
		rd(IDX_C_CONTROL, CTL_WRITE_MASK);
		wr(IDX_B_COUNT_LOW, 8'h55);
		rd(IDX_B_COUNT_LOW, 8'h00);
		apb(1'b0, 8'h30, 8'h00, d, e);
		chk("unmapped pslverr", 32'h1, {31'h0, e});
		// A borrow across the byte boundary proves the counter is one 16-bit value.
		set_c(8'h00, 16'h0100);
		wr(IDX_COMMAND, 8'h02);
		tk(3'b100, 1);
		rd(IDX_C_COUNT_HIGH, 8'h00);
		rd(IDX_C_COUNT_LOW, 8'hff);
		tk(3'b010, 1);
		rd(IDX_C_COUNT_LOW, 8'hff);
		set_c(8'h00, 16'h0002);
		wr(IDX_COMMAND, 8'h02);
		tk(3'b100, 3);
		rd(IDX_COMMAND, 8'h20);
		chk("c underflows", 32'd1, uf_c);
		chk("c flag", 32'h1, {31'h0, timer_c_underflow_flag});
		tk(3'b100, 2);
		chk("c underflows idle", 32'd1, uf_c);
		wr(IDX_COMMAND, 8'h20);
		// The clear lands at the edge that ends the write, so look one edge later.
		@(posedge pclk);
		chk("c flag cleared", 32'h0, {31'h0, timer_c_underflow_flag});
		set_c(8'h00, 16'h0005);
		wr(IDX_COMMAND, 8'h02);
		wr(IDX_C_RELOAD_LOW, 8'h09);
		rd(IDX_C_COUNT_LOW, 8'h05);
		wr(IDX_COMMAND, 8'h02);
		rd(IDX_C_COUNT_LOW, 8'h09);
		set_c(8'h09, 16'h0001);
		wr(IDX_COMMAND, 8'h02);
		tk(3'b010, 2);
		rd(IDX_C_COUNT_LOW, 8'h01);
		rd(IDX_COMMAND, 8'h22);
		tk(3'b010, 2);
		// The pulse follows the last tick by one edge and is counted one edge later.
		repeat (2) @(posedge pclk);
		chk("c restart underflows", 32'd3, uf_c);
		set_c(8'h02, 16'h0001);
		wr(IDX_COMMAND, 8'h02);
		tk(3'b001, 1);
		tk(3'b100, 1);
		rd(IDX_C_COUNT_LOW, 8'h00);
		wr(IDX_B_CONTROL, 8'h00);
		wr(IDX_B_RELOAD_HIGH, 8'h12);
		wr(IDX_B_RELOAD_LOW, 8'h34);
		wr(IDX_COMMAND, 8'h01);
		wr(IDX_B_RELOAD_LOW, 8'h77);
		// Count bytes are only read while no reception is under way.
		rd(IDX_B_COUNT_HIGH, 8'h12);
		rd(IDX_B_COUNT_LOW, 8'h34);
		rd(IDX_B_RELOAD_LOW, 8'h77);
		wr(IDX_COMMAND, 8'h04);
		wr(IDX_B_RELOAD_HIGH, 8'h00);
		wr(IDX_B_RELOAD_LOW, 8'h00);
		set_c(8'h03, 16'h0005);
		wr(IDX_COMMAND, 8'h03);
		tk(3'b100, 1);
		repeat (2) @(posedge pclk);
		chk("b underflows", 32'd1, uf_b);
		rd(IDX_C_COUNT_LOW, 8'h04);
		set_c(8'h00, 16'h0003);
		rfp(3'b100);
		rd(IDX_COMMAND, 8'h00);
		set_c(8'h10, 16'h0003);
		rfp(3'b100);
		rfp(3'b010);
		rd(IDX_COMMAND, 8'h02);
		set_c(8'h90, 16'h0003);
		rfp(3'b100);
		rd(IDX_COMMAND, 8'h02);
		rfp(3'b010);
		rd(IDX_COMMAND, 8'h00);
		// Trimming ignores the receive stop; oscillator edges start it, and an edge or an 11b underflow stops it.
		set_c(8'ha0, 16'h0001);
		rfp(3'b001);
		rfp(3'b011);
		rd(IDX_COMMAND, 8'h02);
		tk(3'b100, 3);
		rd(IDX_C_COUNT_LOW, 8'h00);
		chk("c underflows trim", 32'd3, uf_c);
		rfp(3'b000);
		rfp(3'b001);
		rd(IDX_COMMAND, 8'h00);
		rfp(3'b000);
		set_c(8'hb0, 16'h0001);
		rfp(3'b001);
		tk(3'b100, 2);
		rd(IDX_COMMAND, 8'h20);
		chk("c underflows trim under", 32'd4, uf_c);
		summarize();
	end

endmodule : tb_top

// >>> hdl/rct_countdown.sv
// One 16-bit reloadable countdown timer with start, stop and clock selection.
`timescale 1ns/1ps
module rct_countdown
	import rct_pkg::*;
#(
	parameter int unsigned WIDTH = 16
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire rct_ctrl_type     ctrl,
	input  wire logic [WIDTH-1:0] reload,
	input  wire logic             sw_start,
	input  wire logic             sw_stop,
	input  wire rct_tick_type     tick,
	input  wire logic             cascade_under,
	input  wire rct_rf_type       rf,
	input  wire logic             lfo_rise,
	output logic [WIDTH-1:0]      count_reg,
	output logic                  underflow_reg,
	output logic                  running
);

	rct_state_type    state_reg;
	rct_state_type    state_next;
	logic [WIDTH-1:0] count_next;
	logic             underflow_next;
	logic             lfo_mode;
	logic             start_evt;
	logic             stop_evt;
	logic             tick_sel;

	assign running = (state_reg == ST_RUN);

	always_comb
	begin
		lfo_mode  = ctrl.start_mode_select[1];
		start_evt = sw_start
			| ((ctrl.start_mode_select == START_TX_END) & rf.tx_end)
			| (lfo_mode & lfo_rise & (state_reg == ST_IDLE));
		// The receive stop is masked in trimming mode.
		stop_evt = sw_stop
			| (lfo_mode & lfo_rise & (state_reg == ST_RUN))
			| (~lfo_mode & ctrl.stop_on_receive & rf.rx_first_bits);
		case (ctrl.clock_select)
			CLK_FAST:    tick_sel = tick.fast;
			CLK_SLOW:    tick_sel = tick.slow;
			CLK_TIMER_A: tick_sel = tick.timer_a_under;
			CLK_CASCADE: tick_sel = cascade_under;
			default:     tick_sel = 1'b0;
		endcase
		state_next     = state_reg;
		count_next     = count_reg;
		underflow_next = 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if (start_evt)
				begin
					count_next = reload;
					state_next = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (stop_evt)
					state_next = ST_IDLE;
				else if (start_evt)
					count_next = reload;
				else if (tick_sel)
				begin
					if (count_reg == '0)
					begin
						// Trimming without underflow parks at zero until the stop edge.
						if (ctrl.start_mode_select != START_LFO_PLAIN)
						begin
							underflow_next = 1'b1;
							if (ctrl.auto_restart)
								count_next = reload;
							else
								state_next = ST_IDLE;
						end
					end
					else
						count_next = count_reg - 1'b1;
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg     <= ST_IDLE;
			count_reg     <= COUNT_RESET;
			underflow_reg <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			count_reg     <= count_next;
			underflow_reg <= underflow_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	chk_load_at_start: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_IDLE) && start_evt |=> running && (count_reg == $past(reload)))
		else $error("Timer did not load its reload value at start.");

	chk_stop_on_rx: assert property (@(posedge pclk) disable iff (!presetn)
		running && rf.rx_first_bits && ctrl.stop_on_receive && !lfo_mode |=> !running)
		else $error("Timer kept running after the first received bits.");

	chk_restart_reload: assert property (@(posedge pclk) disable iff (!presetn)
		underflow_next && ctrl.auto_restart |=> running && (count_reg == $past(reload)))
		else $error("Timer did not restart from its reload value.");

	chk_single_shot: assert property (@(posedge pclk) disable iff (!presetn)
		underflow_next && !ctrl.auto_restart |=> !running ##1 !underflow_reg)
		else $error("Single-shot timer did not stop after underflow.");

endmodule : rct_countdown

// >>> hdl/rct_pkg.sv
// Package of register map, field layout and types for the reloadable countdown timers.
package rct_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_B_CONTROL     = 8'h14;
	localparam logic [7:0] IDX_B_RELOAD_HIGH = 8'h15;
	localparam logic [7:0] IDX_B_RELOAD_LOW  = 8'h16;
	localparam logic [7:0] IDX_B_COUNT_HIGH  = 8'h17;
	localparam logic [7:0] IDX_B_COUNT_LOW   = 8'h18;
	localparam logic [7:0] IDX_C_CONTROL     = 8'h19;
	localparam logic [7:0] IDX_C_RELOAD_HIGH = 8'h1a;
	localparam logic [7:0] IDX_C_RELOAD_LOW  = 8'h1b;
	localparam logic [7:0] IDX_C_COUNT_HIGH  = 8'h1c;
	localparam logic [7:0] IDX_C_COUNT_LOW   = 8'h1d;
	localparam logic [7:0] IDX_COMMAND       = 8'h20;

	// Control register layout and writable bits.
	localparam int unsigned CTL_STOP_RX_BIT = 7;
	localparam int unsigned CTL_START_LSB   = 4;
	localparam int unsigned CTL_RESTART_BIT = 3;
	localparam int unsigned CTL_CLK_LSB     = 0;
	localparam logic [7:0]  CTL_WRITE_MASK  = 8'hbb;

	// Command and status register bits.
	localparam int unsigned CMD_START_B = 0;
	localparam int unsigned CMD_START_C = 1;
	localparam int unsigned CMD_STOP_B  = 2;
	localparam int unsigned CMD_STOP_C  = 3;
	localparam int unsigned CMD_FLAG_B  = 4;
	localparam int unsigned CMD_FLAG_C  = 5;

	// Reset values.
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;

	typedef enum logic [1:0] {
		START_NONE      = 2'b00,
		START_TX_END    = 2'b01,
		START_LFO_PLAIN = 2'b10,
		START_LFO_UNDER = 2'b11
	} rct_start_type;

	typedef enum logic [1:0] {
		CLK_FAST    = 2'b00,
		CLK_SLOW    = 2'b01,
		CLK_TIMER_A = 2'b10,
		CLK_CASCADE = 2'b11
	} rct_clksel_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} rct_state_type;

	typedef struct packed {
		logic           stop_on_receive;
		logic           rsv6;
		rct_start_type  start_mode_select;
		logic           auto_restart;
		logic           rsv2;
		rct_clksel_type clock_select;
	} rct_ctrl_type;

	typedef struct packed {
		logic tx_end;
		logic rx_first_bits;
		logic lfo_level;
	} rct_rf_type;

	typedef struct packed {
		logic fast;
		logic slow;
		logic timer_a_under;
	} rct_tick_type;

endpackage : rct_pkg

// >>> hdl/rct_timers.sv
// Top of the timer pair with its APB register slave.
//
// Notes on behaviour
// - A write to the second timer's low reload byte changes its count only at the next start or auto-restart reload.
// - The second timer's running count is readable as a high byte and a low byte.
// - With stop-on-receive set, the third timer halts once the first 4 bits are received.
// - In trimming mode the stop-on-receive bit has no effect.
// - Start mode 00b gives no automatic start and 01b starts at the end of a transmission.
// - Start modes 10b and 11b trim the low-frequency oscillator, starting and stopping on edges.
// - With auto-restart set, the third timer reloads and keeps counting at each underflow.
// - With auto-restart clear, the third timer stops at its first underflow.
// - Every underflow of the third timer sets its underflow flag.
// - Clock select 00b counts the fast tick and 01b counts the slow tick.
// - Clock select 10b counts first-timer underflows and 11b counts the other timer's underflows.
// - The third timer loads both reload bytes at each start and auto-restart; writes wait for the next load.
// - The second timer loads both of its reload bytes together at each start.
`timescale 1ns/1ps
module rct_timers
	import rct_pkg::*;
#(
	parameter int unsigned ADDR_WIDTH = 12
)
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire rct_rf_type            rf,
	input  wire rct_tick_type          tick,
	output logic                       timer_b_underflow,
	output logic                       timer_c_underflow,
	output logic                       timer_c_underflow_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic [7:0]    idx;
	logic          addr_ok;
	logic          wr_en;
	logic          hit;
	logic [7:0]    rd_byte;
	logic          pready_reg;
	logic          pready_next;
	logic [31:0]   prdata_reg;
	logic [31:0]   prdata_next;
	logic          pslverr_reg;
	logic          pslverr_next;

	rct_ctrl_type  ctrl_b_reg;
	rct_ctrl_type  ctrl_b_next;
	rct_ctrl_type  ctrl_c_reg;
	rct_ctrl_type  ctrl_c_next;
	logic [15:0]   reload_b_reg;
	logic [15:0]   reload_b_next;
	logic [15:0]   reload_c_reg;
	logic [15:0]   reload_c_next;
	logic          flag_b_reg;
	logic          flag_b_next;
	logic          flag_c_reg;
	logic          flag_c_next;
	logic          lfo_prev_reg;
	logic          lfo_rise;

	logic [15:0]   count_b;
	logic [15:0]   count_c;
	logic          under_b;
	logic          under_c;
	logic          run_b;
	logic          run_c;
	logic          start_b;
	logic          start_c;
	logic          stop_b;
	logic          stop_c;

	assign idx     = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_WIDTH-1:10] == '0);
	// Writes land only at the edge where the master sees pready high.
	assign wr_en   = psel && penable && pready_reg && pwrite && addr_ok;
	assign start_b = wr_en && (idx == IDX_COMMAND) && pwdata[CMD_START_B];
	assign start_c = wr_en && (idx == IDX_COMMAND) && pwdata[CMD_START_C];
	assign stop_b  = wr_en && (idx == IDX_COMMAND) && pwdata[CMD_STOP_B];
	assign stop_c  = wr_en && (idx == IDX_COMMAND) && pwdata[CMD_STOP_C];
	assign lfo_rise = rf.lfo_level && !lfo_prev_reg;

	always_comb
	begin
		hit     = addr_ok;
		rd_byte = 8'h00;
		case (idx)
			IDX_B_CONTROL:     rd_byte = ctrl_b_reg;
			IDX_B_RELOAD_HIGH: rd_byte = reload_b_reg[15:8];
			IDX_B_RELOAD_LOW:  rd_byte = reload_b_reg[7:0];
			IDX_B_COUNT_HIGH:  rd_byte = count_b[15:8];
			IDX_B_COUNT_LOW:   rd_byte = count_b[7:0];
			IDX_C_CONTROL:     rd_byte = ctrl_c_reg;
			IDX_C_RELOAD_HIGH: rd_byte = reload_c_reg[15:8];
			IDX_C_RELOAD_LOW:  rd_byte = reload_c_reg[7:0];
			IDX_C_COUNT_HIGH:  rd_byte = count_c[15:8];
			IDX_C_COUNT_LOW:   rd_byte = count_c[7:0];
			IDX_COMMAND:
				rd_byte = {2'b00, flag_c_reg, flag_b_reg, 2'b00, run_c, run_b};
			default:           hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, so read data and pready both leave flip-flops.

	always_comb
	begin
		pready_next  = psel && penable && !pready_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		if (pready_next)
		begin
			prdata_next  = (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			pslverr_next = !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg  <= pready_next;
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign pready  = pready_reg;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Software registers and sticky underflow flags.

	always_comb
	begin
		ctrl_b_next   = ctrl_b_reg;
		ctrl_c_next   = ctrl_c_reg;
		reload_b_next = reload_b_reg;
		reload_c_next = reload_c_reg;
		if (wr_en)
		begin
			case (idx)
				IDX_B_CONTROL:     ctrl_b_next = rct_ctrl_type'(pwdata[7:0] & CTL_WRITE_MASK);
				IDX_B_RELOAD_HIGH: reload_b_next[15:8] = pwdata[7:0];
				IDX_B_RELOAD_LOW:  reload_b_next[7:0] = pwdata[7:0];
				IDX_C_CONTROL:     ctrl_c_next = rct_ctrl_type'(pwdata[7:0] & CTL_WRITE_MASK);
				IDX_C_RELOAD_HIGH: reload_c_next[15:8] = pwdata[7:0];
				IDX_C_RELOAD_LOW:  reload_c_next[7:0] = pwdata[7:0];
				default:           ctrl_b_next = ctrl_b_reg;
			endcase
		end
		// An underflow in the clearing cycle keeps the flag set.
		flag_b_next = under_b
			|| (flag_b_reg && !(wr_en && (idx == IDX_COMMAND) && pwdata[CMD_FLAG_B]));
		flag_c_next = under_c
			|| (flag_c_reg && !(wr_en && (idx == IDX_COMMAND) && pwdata[CMD_FLAG_C]));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_b_reg   <= rct_ctrl_type'(CTL_RESET);
			ctrl_c_reg   <= rct_ctrl_type'(CTL_RESET);
			reload_b_reg <= RELOAD_RESET;
			reload_c_reg <= RELOAD_RESET;
			flag_b_reg   <= 1'b0;
			flag_c_reg   <= 1'b0;
			lfo_prev_reg <= 1'b0;
		end
		else
		begin
			ctrl_b_reg   <= ctrl_b_next;
			ctrl_c_reg   <= ctrl_c_next;
			reload_b_reg <= reload_b_next;
			reload_c_reg <= reload_c_next;
			flag_b_reg   <= flag_b_next;
			flag_c_reg   <= flag_c_next;
			lfo_prev_reg <= rf.lfo_level;
		end
	end

	assign timer_c_underflow_flag = flag_c_reg;
	assign timer_b_underflow      = under_b;
	assign timer_c_underflow      = under_c;

	////////////////////////////////////////////////////////////////////////////////
	// The two timers; each cascades from the other's registered underflow pulse.

	rct_countdown #(
		.WIDTH (16)
	) u_timer_b (
		.pclk          (pclk),
		.presetn       (presetn),
		.ctrl          (ctrl_b_reg),
		.reload        (reload_b_reg),
		.sw_start      (start_b),
		.sw_stop       (stop_b),
		.tick          (tick),
		.cascade_under (under_c),
		.rf            (rf),
		.lfo_rise      (lfo_rise),
		.count_reg     (count_b),
		.underflow_reg (under_b),
		.running       (run_b)
	);

	rct_countdown #(
		.WIDTH (16)
	) u_timer_c (
		.pclk          (pclk),
		.presetn       (presetn),
		.ctrl          (ctrl_c_reg),
		.reload        (reload_c_reg),
		.sw_start      (start_c),
		.sw_stop       (stop_c),
		.tick          (tick),
		.cascade_under (under_b),
		.rf            (rf),
		.lfo_rise      (lfo_rise),
		.count_reg     (count_c),
		.underflow_reg (under_c),
		.running       (run_c)
	);

	////////////////////////////////////////////////////////////////////////////////

	chk_flag_on_under: assert property (@(posedge pclk) disable iff (!presetn)
		under_c |=> flag_c_reg)
		else $error("Underflow did not set the flag.");

	chk_reload_deferred: assert property (@(posedge pclk) disable iff (!presetn)
		run_b && wr_en && (idx == IDX_B_RELOAD_LOW) && !start_b
		|=> (count_b == $past(count_b)) || (count_b == $past(count_b) - 16'h0001)
			|| (count_b == $past(reload_b_reg)))
		else $error("Reload write disturbed the running count.");

	chk_ctrl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_c_reg & ~CTL_WRITE_MASK) == 8'h00 && (ctrl_b_reg & ~CTL_WRITE_MASK) == 8'h00)
		else $error("Reserved control bits are not zero.");

	chk_pready_wait: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
		else $error("APB answer not given after exactly one wait state.");

	chk_count_read: assert property (@(posedge pclk) disable iff (!presetn)
		pready_next && !pwrite && addr_ok && (idx == IDX_B_COUNT_LOW)
		|=> prdata_reg == {24'h000000, $past(count_b[7:0])})
		else $error("Count low byte read back wrong.");

	chk_lfo_no_under: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_c_reg.start_mode_select == START_LFO_PLAIN
			&& $past(ctrl_c_reg.start_mode_select) == START_LFO_PLAIN |-> !under_c)
		else $error("Plain trimming mode produced an underflow.");

	cov_cascade: cover property (@(posedge pclk) disable iff (!presetn)
		ctrl_c_reg.clock_select == CLK_CASCADE && under_b && run_c);
	cov_restart: cover property (@(posedge pclk) disable iff (!presetn)
		under_c && run_c ##1 run_c);
	cov_rx_stop: cover property (@(posedge pclk) disable iff (!presetn)
		run_c && rf.rx_first_bits && ctrl_c_reg.stop_on_receive ##1 !run_c);
	cov_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
		under_c && wr_en && (idx == IDX_COMMAND) && pwdata[CMD_FLAG_C]);

endmodule : rct_timers
